// >>> verilog/irq_mask_poll.sv
// interrupt mask, threshold, poll and end-of-service logic behind an axi4-lite slave
//
// Operation
// - three-bit threshold field, resets to seven
// - block requests with level above threshold
// - threshold seven passes every unmasked source
// - mask bits shared with control registers
// - mask register read/write, one masks source
// - master mode mask resets to 07fdh
// - master mask bit layout per source
// - slave mode mask resets to 003dh
// - slave mask bit layout per source
// - snapshot read has no side effect
// - poll read acknowledges highest pending interrupt
// - bit 15 pending, bits 4-0 type
// - master end-of-service: nonspecific or by type
// - slave end-of-service clears by level
// - end-of-service write-only, only clears in-service
// - in-service set on take, blocks same source
`timescale 1ns/10ps
`include "irq_map.svh"
module irq_mask_poll
    import irq_pkg::*;
(
    input  wire logic         aclk,             // 20 MHz system clock
    input  wire logic         aresetn,          // synchronous reset, active low
    input  wire logic         slave_mode_strap, // high selects slave mode, caught in reset
    // axi4-lite write address
    input  wire logic [31:0]  awaddr,
    input  wire logic [2:0]   awprot,
    input  wire logic         awvalid,
    output logic              awready,
    // axi4-lite write data
    input  wire logic [31:0]  wdata,
    input  wire logic [3:0]   wstrb,
    input  wire logic         wvalid,
    output logic              wready,
    // axi4-lite write response
    output logic [1:0]        bresp,
    output logic              bvalid,
    input  wire logic         bready,
    // axi4-lite read address
    input  wire logic [31:0]  araddr,
    input  wire logic [2:0]   arprot,
    input  wire logic         arvalid,
    output logic              arready,
    // axi4-lite read data
    output logic [31:0]       rdata,
    output logic [1:0]        rresp,
    output logic              rvalid,
    input  wire logic         rready,
    // request sources, control registers and core acknowledge
    input  wire logic [10:0]  src_req,          // request levels by source bit
    input  wire level_array_t src_level,        // programmed level per source
    input  ctrl_mask_t        ctrl_mask,        // mask writes from control registers
    input  wire logic         int_ack,          // hardware acknowledge pulse from core
    // results
    output logic [10:0]       source_mask,      // shared mask bits, read by control regs
    output logic [10:0]       in_service,       // in-service bits
    output logic [10:0]       take_pulse,       // one-cycle pulse, source was taken
    output logic              irq_out,          // an eligible request is pending
    output logic [4:0]        irq_type_out,     // type of the highest pending request
    output logic              slave_mode        // captured mode
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic        slave_mode_reg;       // mode caught at reset
    logic [10:0] source_mask_reg;      // shared mask storage
    logic [2:0]  threshold_level_reg;  // threshold field
    logic [10:0] in_service_reg;       // in-service bits
    logic [10:0] take_pulse_reg;       // acknowledge pulses
    logic        irq_out_reg;          // registered pending flag
    logic [4:0]  irq_type_reg;         // registered pending type

    // axi write side
    logic        aw_held_reg;          // write address captured
    logic [31:0] aw_addr_reg;          // captured write address
    logic        w_held_reg;           // write data captured
    logic [31:0] w_data_reg;           // captured write data
    logic [3:0]  w_strb_reg;           // captured byte strobes
    logic        bvalid_reg;           // response pending
    logic [1:0]  bresp_reg;            // response code

    // axi read side
    logic        rvalid_reg;           // read data pending
    logic [31:0] rdata_reg;            // read data
    logic [1:0]  rresp_reg;            // read response code

    // combinational
    logic [10:0] valid_bits;           // legal source positions in this mode
    logic [10:0] eligible;             // requests that may raise an interrupt
    pick_t       pend_pick;            // highest priority eligible request
    pick_t       serv_pick;            // highest priority source in service
    logic        write_fire;           // write takes effect this cycle
    logic        read_fire;            // read address accepted this cycle
    reg_sel_t    write_sel;            // register hit by the write
    reg_sel_t    read_sel;             // register hit by the read
    logic        poll_take;            // poll read acknowledges
    logic        take_now;             // any acknowledge this cycle
    logic [10:0] take_bits;            // source taken this cycle
    logic [10:0] done_bits;            // in-service bits cleared this cycle
    logic [15:0] poll_word;            // poll register content

    ////////////////////////////////////////////////////////////////////////////
    // address decode, used by both channels
    function automatic reg_sel_t decode(input logic [31:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[31:10] == 22'h0 && addr[1:0] == 2'b00) begin
            unique case (addr[9:2])
                `IDX_SERVICE_DONE:       sel = SEL_DONE;
                `IDX_POLL_ACKNOWLEDGE:   sel = SEL_POLL;
                `IDX_POLL_SNAPSHOT:      sel = SEL_SNAPSHOT;
                `IDX_SOURCE_MASK:        sel = SEL_MASK;
                `IDX_PRIORITY_THRESHOLD: sel = SEL_THRESHOLD;
                default:                 sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // one-hot bit of a source index, clipped to the source range
    function automatic logic [10:0] onehot(input logic [3:0] idx);
        return 11'(12'h001 << idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // mode capture: strap is sampled on every clock while reset is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slave_mode_reg <= slave_mode_strap;
        end
    end

    // only documented source positions exist; reserved ones stay zero
    assign valid_bits = slave_mode_reg ? `SRC_VALID_SLAVE : `SRC_VALID_MASTER;

    ////////////////////////////////////////////////////////////////////////////
    // eligibility: request, not masked, not in service, level within threshold
    always_comb begin
        for (int i = 0; i < `NUM_SRC; i++) begin
            eligible[i] = valid_bits[i] && src_req[i]
                          && !source_mask_reg[i]
                          && !in_service_reg[i]
                          && (src_level[i] <= threshold_level_reg);
        end
    end

    // highest pending request
    priority_pick pend_search (
        .candidates (eligible),
        .levels     (src_level),
        .pick       (pend_pick)
    );

    // highest source in service, target of a nonspecific clear
    priority_pick serv_search (
        .candidates (in_service_reg & valid_bits),
        .levels     (src_level),
        .pick       (serv_pick)
    );

    // poll word: flag in bit 15, type in low bits, zero elsewhere
    always_comb begin
        poll_word = 16'h0000;
        poll_word[`PENDING_FLAG_BIT] = pend_pick.found;
        if (pend_pick.found) begin
            poll_word[`PENDING_TYPE_MSB:0] = pend_pick.irq_type;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi write channel capture; address and data accepted in either order
    assign awready    = !aw_held_reg && !bvalid_reg;
    assign wready     = !w_held_reg && !bvalid_reg;
    assign write_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign write_sel  = decode(aw_addr_reg);

    // write address holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h0000_0000;
        end else if (awvalid && awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (write_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    // write data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (write_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // write response; unmapped address answers slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `RESP_OKAY;
        end else if (write_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (write_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp  = bresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // threshold register; only the low byte lane carries the field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            threshold_level_reg <= `THRESHOLD_RST;
        end else if (write_fire && write_sel == SEL_THRESHOLD && w_strb_reg[0]) begin
            threshold_level_reg <= w_data_reg[`THRESHOLD_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source mask: one storage written from the bus or from a control register;
    // a control register write to a bit wins over the bus in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_mask_reg <= slave_mode_strap ? `SOURCE_MASK_RST_SLAVE
                                                : `SOURCE_MASK_RST_MASTER;
        end else begin
            for (int i = 0; i < `NUM_SRC; i++) begin
                if (!valid_bits[i]) begin
                    source_mask_reg[i] <= 1'b0;
                end else if (ctrl_mask.write_en[i]) begin
                    source_mask_reg[i] <= ctrl_mask.value[i];
                end else if (write_fire && write_sel == SEL_MASK
                             && w_strb_reg[i / 8]) begin
                    source_mask_reg[i] <= w_data_reg[i];
                end
            end
        end
    end

    assign source_mask = source_mask_reg;

    ////////////////////////////////////////////////////////////////////////////
    // end-of-service decode; write-only, clears in-service and nothing else
    always_comb begin
        done_bits = 11'h000;
        if (write_fire && write_sel == SEL_DONE && w_strb_reg[0]) begin
            if (slave_mode_reg) begin
                // slave: every source programmed at the written level
                for (int i = 0; i < `NUM_SRC; i++) begin
                    if (src_level[i] == w_data_reg[`LEVEL_SELECT_MSB:0]) begin
                        done_bits[i] = 1'b1;
                    end
                end
            end else if (w_strb_reg[1] && w_data_reg[`NONSPECIFIC_BIT]) begin
                // nonspecific: highest priority source in service
                if (serv_pick.found) begin
                    done_bits = onehot(serv_pick.index);
                end
            end else begin
                // specific: the source of the written type
                for (int i = 0; i < `NUM_SRC; i++) begin
                    if (w_data_reg[`PENDING_TYPE_MSB:0] == `TYPE_BASE + 5'(i)) begin
                        done_bits[i] = 1'b1;
                    end
                end
            end
            done_bits = done_bits & valid_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge: hardware acknowledge or a poll read takes the winner
    assign read_sel  = decode(araddr);
    assign read_fire = arvalid && arready;
    assign poll_take = read_fire && read_sel == SEL_POLL;
    assign take_now  = (int_ack || poll_take) && pend_pick.found;
    assign take_bits = take_now ? onehot(pend_pick.index) : 11'h000;

    // in-service bits; a take in the clearing cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_service_reg <= 11'h000;
        end else begin
            in_service_reg <= ((in_service_reg & ~done_bits) | take_bits)
                              & valid_bits;
        end
    end

    // one-cycle pulse so the request source can drop its request; a poll read
    // pulses just as a hardware acknowledge does, handler entry is left to software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            take_pulse_reg <= 11'h000;
        end else begin
            take_pulse_reg <= take_bits;
        end
    end

    assign in_service = in_service_reg;
    assign take_pulse = take_pulse_reg;

    ////////////////////////////////////////////////////////////////////////////
    // registered pending indication toward the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_out_reg  <= 1'b0;
            irq_type_reg <= 5'h00;
        end else begin
            irq_out_reg  <= pend_pick.found;
            irq_type_reg <= pend_pick.irq_type;
        end
    end

    assign irq_out      = irq_out_reg;
    assign irq_type_out = irq_type_reg;
    assign slave_mode   = slave_mode_reg;

    ////////////////////////////////////////////////////////////////////////////
    // axi read channel; one read in flight, answered the cycle after accept
    assign arready = !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `RESP_OKAY;
        end else if (read_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
            unique case (read_sel)
                SEL_POLL:      rdata_reg[15:0] <= poll_word;
                SEL_SNAPSHOT:  rdata_reg[15:0] <= poll_word;
                SEL_MASK:      rdata_reg[10:0] <= source_mask_reg & valid_bits;
                SEL_THRESHOLD: rdata_reg[`THRESHOLD_MSB:0] <= threshold_level_reg;
                // write-only register reads as zero
                SEL_DONE:      rdata_reg <= 32'h0000_0000;
                SEL_NONE:      rresp_reg <= `RESP_SLVERR;
            endcase
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata  = rdata_reg;
    assign rresp  = rresp_reg;

endmodule

// >>> verilog/irq_map.svh
// offsets, field positions, reset values and codes of the mask, poll and end-of-service block
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// register indices; byte address on the bus is four times the index
`define IDX_SERVICE_DONE       8'h22
`define IDX_POLL_ACKNOWLEDGE   8'h24
`define IDX_POLL_SNAPSHOT      8'h26
`define IDX_SOURCE_MASK        8'h28
`define IDX_PRIORITY_THRESHOLD 8'h2a

// source count and legal source positions per mode
`define NUM_SRC                11
`define SRC_VALID_MASTER       11'h7fd
`define SRC_VALID_SLAVE        11'h03d

// reset values
`define SOURCE_MASK_RST_MASTER 11'h7fd
`define SOURCE_MASK_RST_SLAVE  11'h03d
`define THRESHOLD_RST          3'h7

// field positions
`define THRESHOLD_MSB          2
`define PENDING_FLAG_BIT       15
`define PENDING_TYPE_MSB       4
`define NONSPECIFIC_BIT        15
`define LEVEL_SELECT_MSB       2

// interrupt type of source bit 0; each higher bit adds one (arbitrary plain base)
`define TYPE_BASE              5'h08

// axi response codes
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// >>> verilog/irq_pkg.sv
// types shared by the interrupt mask, poll and end-of-service logic
package irq_pkg;

    // priority level of every source, index = source bit
    typedef logic [10:0][2:0] level_array_t;

    // result of a priority search
    typedef struct packed {
        logic       found;      // any candidate present
        logic [3:0] index;      // source bit of the winner
        logic [4:0] irq_type;   // interrupt type of the winner
    } pick_t;

    // mask-bit write path from the per-source control registers
    typedef struct packed {
        logic [10:0] write_en;  // one strobe per source
        logic [10:0] value;     // new mask bit per source
    } ctrl_mask_t;

    // register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE      = 3'b000,
        SEL_DONE      = 3'b001,
        SEL_POLL      = 3'b010,
        SEL_SNAPSHOT  = 3'b011,
        SEL_MASK      = 3'b100,
        SEL_THRESHOLD = 3'b101
    } reg_sel_t;

endpackage

// >>> verilog/priority_pick.sv
// combinational search for the highest priority source among a set of candidates
`timescale 1ns/10ps
`include "irq_map.svh"
module priority_pick
    import irq_pkg::*;
(
    input  wire logic         [10:0] candidates,  // sources taking part
    input  wire level_array_t        levels,      // programmed level per source
    output pick_t                    pick         // winner, lowest level then lowest bit
);

    ////////////////////////////////////////////////////////////////////////////
    // linear scan; strict compare keeps the lowest bit on a tie of levels
    always_comb begin
        logic [2:0] best_level;   // level of the winner so far
        best_level    = 3'h7;
        pick          = '0;
        for (int i = 0; i < `NUM_SRC; i++) begin
            if (candidates[i] && (!pick.found || levels[i] < best_level)) begin
                pick.found    = 1'b1;
                pick.index    = 4'(i);
                pick.irq_type = `TYPE_BASE + 5'(i);
                best_level    = levels[i];
            end
        end
    end

endmodule

// >>> tb/irq_source_model.sv
// request sources: a level request held until the controller takes it
`timescale 1ns/10ps
module irq_source_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [10:0] raise,      // one-cycle request from the bench
    input  wire logic [10:0] take_pulse, // taken source, drops its request
    output logic      [10:0] src_req
);
    // a raise in the same cycle as a take wins, so a fresh event is never lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_req <= 11'h000;
        end else begin
            src_req <= (src_req & ~take_pulse) | raise;
        end
    end
endmodule

// >>> tb/irq_mask_poll_asserts.sv
// port checks on the mask, poll and end-of-service block
`timescale 1ns/10ps
`include "irq_map.svh"
module irq_mask_poll_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [10:0] src_req,
    input wire logic [10:0] source_mask,
    input wire logic [10:0] in_service,
    input wire logic [10:0] take_pulse,
    input wire logic        irq_out,
    input wire logic [4:0]  irq_type_out,
    input wire logic        slave_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // both write channels taken at one edge
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    // read address taken
    sequence s_rd_taken;
        arvalid && arready;
    endsequence
    chk_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
        else $error("write response not on time");
    chk_read_answer: assert property (s_rd_taken |=> rvalid)
        else $error("read response not on time");
    chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    chk_take_service: assert property (|take_pulse |-> $onehot(take_pulse)
        && (in_service & take_pulse) == take_pulse) else $error("taken source not in service");
    chk_take_once: assert property (|take_pulse |=> !(|(take_pulse & $past(take_pulse))))
        else $error("take pulse longer than one cycle");
    chk_mask_reset: assert property ($rose(aresetn) |-> source_mask == (slave_mode
        ? `SOURCE_MASK_RST_SLAVE : `SOURCE_MASK_RST_MASTER)) else $error("mask reset value");
    chk_irq_cause: assert property (irq_out |-> $past(|(src_req & ~source_mask & ~in_service)))
        else $error("request raised without an unmasked source");
    chk_irq_type: assert property (irq_out |-> irq_type_out >= `TYPE_BASE
        && irq_type_out <= `TYPE_BASE + 5'h0a) else $error("pending type out of range");
endmodule

// >>> tb/irq_mask_poll_test.sv
// self-checking bench for the mask, poll and end-of-service block
`timescale 1ns/10ps
`include "irq_map.svh"
module irq_mask_poll_test import irq_pkg::*; ;
    localparam logic [31:0] A_DONE = {22'h0, `IDX_SERVICE_DONE, 2'b00};
    localparam logic [31:0] A_POLL = {22'h0, `IDX_POLL_ACKNOWLEDGE, 2'b00};
    localparam logic [31:0] A_SNAP = {22'h0, `IDX_POLL_SNAPSHOT, 2'b00};
    localparam logic [31:0] A_MASK = {22'h0, `IDX_SOURCE_MASK, 2'b00};
    localparam logic [31:0] A_THR  = {22'h0, `IDX_PRIORITY_THRESHOLD, 2'b00};
    logic         aclk, aresetn, slave_mode_strap, int_ack, irq_out, slave_mode;
    logic         awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready;
    logic [31:0]  awaddr, wdata, araddr, rdata;
    logic [2:0]   awprot, arprot;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp;
    logic [10:0]  src_req, source_mask, in_service, take_pulse, raise;
    logic [4:0]   irq_type_out;
    level_array_t src_level;
    ctrl_mask_t   ctrl_mask;
    int           miscompares, checked, cycles;

    irq_mask_poll uut (.aclk, .aresetn, .slave_mode_strap, .awaddr, .awprot, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .src_req, .src_level,
        .ctrl_mask, .int_ack, .source_mask, .in_service, .take_pulse, .irq_out,
        .irq_type_out, .slave_mode);
    irq_source_model srcs (.aclk, .aresetn, .raise, .take_pulse, .src_req);
    ////////////////////////////////////////////////////////////////////////
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r = 2'b00);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check_resp(bresp, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check_resp(rresp, r);
        check_reg(rdata, e);
    endtask
    task automatic svc(input logic [10:0] e);
        check_reg({21'h0, in_service}, {21'h0, e});
    endtask
    // one-cycle event on the chosen sources
    task automatic pulse_src(input logic [10:0] b);
        @(posedge aclk);
        raise <= b;
        @(posedge aclk);
        raise <= 11'h000;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        rd(A_MASK, 32'h7fd);
        rd(A_THR, 32'h7);
        rd(A_DONE, 32'h0);
        wr(32'h4, 32'h0, `RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic test_mask();
        wr(A_MASK, 32'hffff);
        rd(A_MASK, 32'h7fd);
        wr(A_MASK, 32'h0);
        rd(A_MASK, 32'h0);
        @(posedge aclk);
        ctrl_mask <= '{write_en: 11'h010, value: 11'h010};
        @(posedge aclk);
        ctrl_mask <= '0;
        rd(A_MASK, 32'h010);
        wr(A_MASK, 32'h0);
        check_reg({21'h0, source_mask}, 32'h0);
        $display("test mask done");
    endtask
    task automatic test_threshold();
        wr(A_THR, 32'hfffc);
        rd(A_THR, 32'h4);
        pulse_src(11'h010);
        rd(A_SNAP, 32'h0);
        wr(A_THR, 32'h5);
        rd(A_SNAP, 32'h800c);
        $display("test threshold done");
    endtask
    task automatic test_poll();
        wr(A_THR, 32'h7);
        pulse_src(11'h201);
        rd(A_SNAP, 32'h8011);
        rd(A_SNAP, 32'h8011);
        check_reg({26'h0, irq_out, irq_type_out}, 32'h31);
        svc(11'h000);
        rd(A_POLL, 32'h8011);
        svc(11'h200);
        pulse_src(11'h200);
        rd(A_SNAP, 32'h800c);
        rd(A_POLL, 32'h800c);
        rd(A_SNAP, 32'h8008);
        svc(11'h210);
        $display("test poll done");
    endtask
    task automatic test_eoi();
        wr(A_DONE, 32'h8000);
        svc(11'h010);
        rd(A_SNAP, 32'h8011);
        @(posedge aclk);
        int_ack <= 1'b1;
        @(posedge aclk);
        int_ack <= 1'b0;
        @(posedge aclk);
        svc(11'h210);
        wr(A_DONE, 32'h000c);
        svc(11'h200);
        wr(A_DONE, 32'h0011);
        svc(11'h000);
        rd(A_DONE, 32'h0);
        $display("test end of service done");
    endtask
    // second reset with the strap high
    task automatic test_slave();
        @(posedge aclk);
        aresetn <= 1'b0;
        slave_mode_strap <= 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_MASK, 32'h03d);
        wr(A_MASK, 32'hffde);
        rd(A_MASK, 32'h01c);
        pulse_src(11'h420);
        rd(A_POLL, 32'h800d);
        rd(A_SNAP, 32'h0);
        svc(11'h020);
        wr(A_DONE, 32'h3);
        svc(11'h000);
        $display("test slave mode done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // a hang counts as a mismatch
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        {aresetn, slave_mode_strap, int_ack, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, awprot, arprot, raise, miscompares, checked, cycles} = '0;
        wstrb = 4'hf;
        ctrl_mask = '0;
        src_level = {3'h7, 3'h2, 3'h7, 3'h7, 3'h7, 3'h3, 3'h5, 3'h7, 3'h7, 3'h7, 3'h7};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_mask();
        test_threshold();
        test_poll();
        test_eoi();
        test_slave();
        stop_test();
    end
endmodule
bind irq_mask_poll irq_mask_poll_asserts chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
    .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
    .src_req, .source_mask, .in_service, .take_pulse, .irq_out, .irq_type_out, .slave_mode);
